// ===== design/rswl_pkg.sv
package rswl_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;

    // power-on hold time of the reset output
    localparam int unsigned POR_DELAY_US = 5000;
    localparam int unsigned POR_CYC = (POR_DELAY_US * (CLK_HZ / 1_000_000));
    localparam int unsigned POR_CW = 18;

    // minimum visible led pulse
    localparam int unsigned LED_STRETCH_US = 10000;
    localparam int unsigned LED_CYC = (LED_STRETCH_US * (CLK_HZ / 1_000_000));
    localparam int unsigned LED_CW = 19;

    // 6 MHz out of 40 MHz: toggle 3 times every 10 cycles
    localparam int unsigned OSC_HZ = 6_000_000;
    localparam logic [3:0] OSC_STEP = 4'h3;
    localparam logic [3:0] OSC_MOD = 4'ha;

    // reset values
    localparam logic [1:0] RST_SYNC_INIT = 2'h3;
    localparam logic STRAP_INIT = 1'h0;
    localparam logic RING_INIT = 1'h1;

    // strap sampled once its synchroniser has passed the pin after reset
    localparam logic [2:0] STRAP_CAPTURE = 3'h4;
    localparam logic [2:0] STRAP_DONE = 3'h5;

    typedef enum logic [1:0] {
        RSWL_ROUT_HIZ = 2'b00,
        RSWL_ROUT_HIGH = 2'b01,
        RSWL_ROUT_LOW = 2'b10
    } rswl_rout_t;

    // status from the usb / uart core, same clock
    typedef struct packed {
        logic suspended;
        logic configured;
        logic tx_event;
        logic rx_event;
        logic uart_tx_busy;
        logic wake_enable;
    } rswl_core_t;

    // open-collector / tri-state pin pair
    typedef struct packed {
        logic out;
        logic oe_n;
    } rswl_pin_t;

endpackage

// ===== design/rswl_sync3.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; level changes once stages 2 and 3 agree
module rswl_sync3
    import rswl_pkg::*;
#(
    parameter logic INIT = 1'h0
)
(
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // pin and result
    input wire logic i_pin,
    output logic o_level
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
        end
        else
        begin
            s1_q <= i_pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            level_q <= INIT;
        else if (s2_q == s3_q)
            level_q <= s3_q;
    end

    assign o_level = level_q;

    agree_only_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (level_q != $past(level_q)) |-> ($past(s2_q) == $past(s3_q)))
        else $error("level changed without agreement");

endmodule // rswl_sync3

// ===== design/rswl_top.sv
`timescale 1ns/1ps
module rswl_top
    import rswl_pkg::*;
#(
    parameter int unsigned P_POR_CYC = POR_CYC,
    parameter int unsigned P_LED_CYC = LED_CYC
)
(
    // clock and power-on reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // pins in
    input wire logic i_reset_n,
    input wire logic i_test_strap,
    input wire logic i_ring_indicator_n,
    // core status
    input wire rswl_core_t i_core,
    // reset output pin
    output logic o_reset_output_n,
    output logic o_reset_output_oe_n,
    // activity leds, open collector
    output logic o_tx_activity_led_n,
    output logic o_tx_activity_led_oe_n,
    output logic o_rx_activity_led_n,
    output logic o_rx_activity_led_oe_n,
    // clock and power pins
    output logic o_osc_clock_out,
    output logic o_suspend_indicator_n,
    output logic o_power_switch_enable_n,
    output logic o_rs485_driver_enable,
    // to the core
    output logic o_test_mode,
    output logic o_resume_req,
    output logic o_core_reset
);

    function automatic logic [LED_CW-1:0] led_next(input logic evt,
                                                   input logic [LED_CW-1:0] cnt);
        if (evt)
            led_next = LED_CW'(P_LED_CYC);
        else if (cnt != '0)
            led_next = cnt - 1'b1;
        else
            led_next = '0;
    endfunction

    // reset pin: asserts at once, releases through two flops
    logic ext_rst_s1_q;
    logic ext_rst_q;

    always_ff @(posedge i_mclk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ext_rst_s1_q <= RST_SYNC_INIT[0];
            ext_rst_q <= RST_SYNC_INIT[1];
        end
        else
        begin
            ext_rst_s1_q <= 1'b0;
            ext_rst_q <= ext_rst_s1_q;
        end
    end

    // usb bus reset has no path in here
    logic rst_int;
    assign rst_int = i_rst | ext_rst_q;

    // reset output pin
    rswl_rout_t rout_q;
    logic [POR_CW-1:0] por_cnt_q;
    logic por_done_q;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            por_cnt_q <= '0;
            por_done_q <= 1'b0;
        end
        else if (!por_done_q)
        begin
            if (por_cnt_q == POR_CW'(P_POR_CYC - 1))
                por_done_q <= 1'b1;
            else
                por_cnt_q <= por_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            rout_q <= RSWL_ROUT_HIZ;
        else
        begin
            case (rout_q)
                RSWL_ROUT_HIZ:
                begin
                    if (ext_rst_q)
                        rout_q <= RSWL_ROUT_LOW;
                    else if (por_done_q)
                        rout_q <= RSWL_ROUT_HIGH;
                end
                RSWL_ROUT_HIGH:
                begin
                    if (ext_rst_q)
                        rout_q <= RSWL_ROUT_LOW;
                end
                RSWL_ROUT_LOW:
                begin
                    if (!ext_rst_q)
                        rout_q <= por_done_q ? RSWL_ROUT_HIGH : RSWL_ROUT_HIZ;
                end
                default:
                    rout_q <= RSWL_ROUT_HIZ;
            endcase
        end
    end

    rswl_pin_t rout_pin_q;
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            rout_pin_q <= '{out: 1'b1, oe_n: 1'b1};
        else if (ext_rst_q)
            rout_pin_q <= '{out: 1'b0, oe_n: 1'b0};
        else
        begin
            case (rout_q)
                RSWL_ROUT_HIGH:
                    rout_pin_q <= '{out: 1'b1, oe_n: 1'b0};
                RSWL_ROUT_LOW:
                    rout_pin_q <= '{out: 1'b0, oe_n: 1'b0};
                default:
                    rout_pin_q <= '{out: 1'b1, oe_n: 1'b1};
            endcase
        end
    end

    assign o_reset_output_n = rout_pin_q.out;
    assign o_reset_output_oe_n = rout_pin_q.oe_n;

    logic core_rst_q;
    always_ff @(posedge i_mclk)
    begin
        core_rst_q <= rst_int;
    end

    assign o_core_reset = core_rst_q;

    // pin synchronisers
    logic strap_lvl;
    logic ring_lvl;
    rswl_sync3 #(
        .INIT(STRAP_INIT)
    ) u_strap_sync (
        .i_mclk(i_mclk),
        .i_rst(rst_int),
        .i_pin(i_test_strap),
        .o_level(strap_lvl)
    );

    rswl_sync3 #(
        .INIT(RING_INIT)
    ) u_ring_sync (
        .i_mclk(i_mclk),
        .i_rst(rst_int),
        .i_pin(i_ring_indicator_n),
        .o_level(ring_lvl)
    );

    // strap caught once the synchroniser has settled after reset
    logic [2:0] strap_wait_q;
    logic test_mode_q;
    always_ff @(posedge i_mclk)
    begin
        if (rst_int)
        begin
            strap_wait_q <= '0;
            test_mode_q <= STRAP_INIT;
        end
        else if (strap_wait_q != STRAP_DONE)
        begin
            strap_wait_q <= strap_wait_q + 1'b1;
            if (strap_wait_q == STRAP_CAPTURE)
                test_mode_q <= strap_lvl;
        end
    end

    assign o_test_mode = test_mode_q;

    // remote wake on ring indicator falling edge
    logic ring_prev_q;
    logic resume_q;

    always_ff @(posedge i_mclk)
    begin
        if (rst_int)
        begin
            ring_prev_q <= RING_INIT;
            resume_q <= 1'b0;
        end
        else
        begin
            ring_prev_q <= ring_lvl;
            resume_q <= ring_prev_q & ~ring_lvl & i_core.suspended
                        & i_core.wake_enable;
        end
    end

    assign o_resume_req = resume_q;

    // activity leds
    logic [LED_CW-1:0] tx_cnt_q;
    logic [LED_CW-1:0] rx_cnt_q;
    rswl_pin_t tx_led_q;
    rswl_pin_t rx_led_q;
    logic [LED_CW-1:0] tx_cnt_d;
    logic [LED_CW-1:0] rx_cnt_d;

    assign tx_cnt_d = led_next(i_core.tx_event, tx_cnt_q);
    assign rx_cnt_d = led_next(i_core.rx_event, rx_cnt_q);

    always_ff @(posedge i_mclk)
    begin
        if (rst_int)
        begin
            tx_cnt_q <= '0;
            tx_led_q <= '{out: 1'b0, oe_n: 1'b1};
            rx_cnt_q <= '0;
            rx_led_q <= '{out: 1'b0, oe_n: 1'b1};
        end
        else
        begin
            tx_cnt_q <= tx_cnt_d;
            tx_led_q <= '{out: 1'b0, oe_n: (tx_cnt_d == '0)};
            rx_cnt_q <= rx_cnt_d;
            rx_led_q <= '{out: 1'b0, oe_n: (rx_cnt_d == '0)};
        end
    end

    assign o_tx_activity_led_n = tx_led_q.out;
    assign o_tx_activity_led_oe_n = tx_led_q.oe_n;
    assign o_rx_activity_led_n = rx_led_q.out;
    assign o_rx_activity_led_oe_n = rx_led_q.oe_n;

    // oscillator output, held low in suspend
    logic [3:0] osc_acc_q;
    logic osc_q;
    logic [4:0] osc_sum;

    assign osc_sum = {1'b0, osc_acc_q} + {1'b0, OSC_STEP};

    always_ff @(posedge i_mclk)
    begin
        if (rst_int || i_core.suspended)
        begin
            osc_acc_q <= '0;
            osc_q <= 1'b0;
        end
        else if (osc_sum >= {1'b0, OSC_MOD})
        begin
            osc_acc_q <= 4'(osc_sum - {1'b0, OSC_MOD});
            osc_q <= ~osc_q;
        end
        else
            osc_acc_q <= osc_sum[3:0];
    end

    assign o_osc_clock_out = osc_q;

    // power and line control pins
    logic susp_n_q;
    logic pwr_n_q;
    logic de_q;

    always_ff @(posedge i_mclk)
    begin
        if (rst_int)
        begin
            susp_n_q <= 1'b1;
            pwr_n_q <= 1'b1;
            de_q <= 1'b0;
        end
        else
        begin
            susp_n_q <= ~i_core.suspended;
            pwr_n_q <= ~(i_core.configured & ~i_core.suspended);
            de_q <= i_core.uart_tx_busy;
        end
    end

    assign o_suspend_indicator_n = susp_n_q;
    assign o_power_switch_enable_n = pwr_n_q;
    assign o_rs485_driver_enable = de_q;

    reset_output_n_low_a: assert property (@(posedge i_mclk)
        ext_rst_q |=> (!o_reset_output_n && !o_reset_output_oe_n))
        else $error("reset output not low during external reset");
    por_float_a: assert property (@(posedge i_mclk) disable iff (i_rst)
        (!por_done_q && !ext_rst_q && !$past(ext_rst_q)) |-> o_reset_output_oe_n)
        else $error("reset output driven before power-on delay");
    por_drive_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        (por_done_q && $past(por_done_q) && !$past(ext_rst_q)) |=>
        (o_reset_output_n && !o_reset_output_oe_n))
        else $error("reset output not high after power-on delay");
    tx_stretch_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        i_core.tx_event |=> (!o_tx_activity_led_oe_n)[*8])
        else $error("tx led pulse too short");
    rx_pulse_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        i_core.rx_event |=> (!o_rx_activity_led_oe_n && !o_rx_activity_led_n)[*8])
        else $error("rx led pulse too short");
    osc_stop_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        i_core.suspended |=> !o_osc_clock_out)
        else $error("oscillator output running in suspend");
    osc_run_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        (!i_core.suspended)[*5] |-> (o_osc_clock_out != $past(o_osc_clock_out, 4)
        || o_osc_clock_out != $past(o_osc_clock_out, 2)))
        else $error("oscillator output stuck while awake");
    susp_ind_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        $past(!rst_int) |-> (o_suspend_indicator_n == !$past(i_core.suspended)))
        else $error("suspend indicator wrong");
    pwr_sw_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        (i_core.configured && !i_core.suspended) |=> !o_power_switch_enable_n)
        else $error("power switch not enabled once configured");
    pwr_off_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        i_core.suspended |=> o_power_switch_enable_n)
        else $error("power switch enabled during suspend");
    driver_en_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        i_core.uart_tx_busy |=> o_rs485_driver_enable)
        else $error("rs485 driver not enabled during transmit");
    wake_only_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        o_resume_req |-> ($past(i_core.suspended) && $past(i_core.wake_enable)))
        else $error("resume requested outside enabled suspend");
    strap_hold_a: assert property (@(posedge i_mclk) disable iff (rst_int)
        (strap_wait_q == STRAP_DONE && $past(strap_wait_q) == STRAP_DONE)
        |-> $stable(o_test_mode))
        else $error("test mode changed after capture");

endmodule // rswl_top

// ===== test/rswl_ext_logic.sv
`timescale 1ns/1ps
module rswl_ext_logic #(
    parameter int RING_CYC = 20
)
(
    // clock and reset pin from the block
    input wire logic i_mclk,
    input wire logic i_rout_n,
    input wire logic i_rout_oe_n,
    // bench control
    input wire logic i_hold,
    input wire logic i_strap,
    input wire logic i_ring_go,
    // pins to the block
    output logic o_reset_n,
    output logic o_test_strap,
    output logic o_ring_n,
    output logic o_rst_wire
);
    int cnt = 0;
    initial
    begin
        o_reset_n = 1'h1;
        o_test_strap = 1'h0;
    end
    // pull-down keeps the mcu in reset while the pin floats
    assign o_rst_wire = i_rout_oe_n ? 1'h0 : i_rout_n;
    assign o_ring_n = (cnt == 0);
    always @(posedge i_mclk)
    begin
        o_reset_n <= !i_hold;
        o_test_strap <= i_strap;
        if (i_ring_go && cnt == 0)
            cnt <= RING_CYC;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
endmodule // rswl_ext_logic

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import rswl_pkg::*;
;
    localparam int POR = 20;
    localparam int LED = 8;
    logic i_mclk = 1'h0;
    logic i_rst = 1'h1;
    rswl_core_t i_core = '0;
    logic hold = 1'h0;
    logic strap = 1'h0;
    logic ring_go = 1'h0;
    logic i_reset_n, i_test_strap, i_ring_indicator_n, rst_wire;
    logic o_reset_output_n, o_reset_output_oe_n, o_osc_clock_out;
    logic o_tx_activity_led_n, o_tx_activity_led_oe_n;
    logic o_rx_activity_led_n, o_rx_activity_led_oe_n;
    logic o_suspend_indicator_n, o_power_switch_enable_n, o_rs485_driver_enable;
    logic o_test_mode, o_resume_req, o_core_reset;
    int mismatches = 0;
    int num_checks = 0;

    rswl_top #(.P_POR_CYC(POR), .P_LED_CYC(LED)) rswl_top_i (.i_mclk, .i_rst,
        .i_reset_n, .i_test_strap, .i_ring_indicator_n, .i_core,
        .o_reset_output_n, .o_reset_output_oe_n, .o_tx_activity_led_n,
        .o_tx_activity_led_oe_n, .o_rx_activity_led_n, .o_rx_activity_led_oe_n,
        .o_osc_clock_out, .o_suspend_indicator_n, .o_power_switch_enable_n,
        .o_rs485_driver_enable, .o_test_mode, .o_resume_req, .o_core_reset);
    rswl_ext_logic rswl_ext_logic_i (.i_mclk, .i_rout_n(o_reset_output_n),
        .i_rout_oe_n(o_reset_output_oe_n), .i_hold(hold), .i_strap(strap),
        .i_ring_go(ring_go), .o_reset_n(i_reset_n), .o_test_strap(i_test_strap),
        .o_ring_n(i_ring_indicator_n), .o_rst_wire(rst_wire));

    initial
    begin
        forever #12.5 i_mclk = ~i_mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_mclk);
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic toggles(output int tg);
        logic prev;
        tg = 0;
        prev = o_osc_clock_out;
        repeat (20)
        begin
            cyc(1);
            tg += (o_osc_clock_out !== prev);
            prev = o_osc_clock_out;
        end
    endtask

    task automatic t_por(input logic s);
        int n;
        strap = s;
        i_rst = 1'h1;
        cyc(4);
        chk({o_reset_output_oe_n, rst_wire}, 2'h2);
        i_rst = 1'h0;
        n = 0;
        while (o_reset_output_oe_n !== 1'h0)
        begin
            cyc(1);
            n++;
            if (n > 100)
            begin
                mismatches++;
                $display("Error at %0t: got %h expected %h", $time, n, POR);
                conclude();
            end
        end
        chk(n >= POR && n <= POR + 2, 1'h1);
        chk({o_reset_output_n, rst_wire, o_test_mode}, {2'h3, s});
        $display("test por done");
    endtask

    task automatic t_ext;
        hold = 1'h1;
        cyc(3);
        chk({rst_wire, o_reset_output_oe_n, o_core_reset}, 3'h1);
        hold = 1'h0;
        cyc(8);
        chk({rst_wire, o_reset_output_oe_n, o_core_reset}, 3'h4);
        $display("test ext reset done");
    endtask

    task automatic t_led;
        int lows;
        for (int k = 0; k < 2; k++)
        begin
            lows = 0;
            i_core.tx_event = (k == 0);
            i_core.rx_event = (k == 1);
            cyc(1);
            i_core.tx_event = 1'h0;
            i_core.rx_event = 1'h0;
            for (int c = 0; c < LED + 4; c++)
            begin
                lows += k ? !o_rx_activity_led_oe_n : !o_tx_activity_led_oe_n;
                chk({o_tx_activity_led_n, o_rx_activity_led_n}, 2'h0);
                cyc(1);
            end
            chk(lows, LED);
        end
        $display("test leds done");
    endtask

    task automatic t_susp;
        int tg;
        chk({o_power_switch_enable_n, o_suspend_indicator_n}, 2'h3);
        i_core.configured = 1'h1;
        cyc(2);
        chk({o_power_switch_enable_n, o_suspend_indicator_n}, 2'h1);
        toggles(tg);
        chk(tg, 6);
        i_core.suspended = 1'h1;
        cyc(3);
        chk({o_power_switch_enable_n, o_suspend_indicator_n, rst_wire}, 3'h5);
        toggles(tg);
        chk({tg[3:0], o_osc_clock_out}, 5'h00);
        i_core.suspended = 1'h0;
        cyc(2);
        chk({o_power_switch_enable_n, o_suspend_indicator_n}, 2'h1);
        $display("test suspend done");
    endtask

    task automatic t_wake;
        int n;
        i_core.suspended = 1'h1;
        for (int k = 1; k >= 0; k--)
        begin
            i_core.wake_enable = k[0];
            n = 0;
            cyc(2);
            ring_go = 1'h1;
            cyc(1);
            ring_go = 1'h0;
            repeat (40)
            begin
                cyc(1);
                n += o_resume_req;
            end
            chk(n, k);
        end
        i_core.suspended = 1'h0;
        $display("test wake done");
    endtask

    task automatic t_de;
        i_core.uart_tx_busy = 1'h1;
        cyc(1);
        chk(o_rs485_driver_enable, 1'h1);
        i_core.uart_tx_busy = 1'h0;
        cyc(1);
        chk(o_rs485_driver_enable, 1'h0);
        $display("test rs485 done");
    endtask

    initial
    begin
        t_por(1'h1);
        t_por(1'h0);
        t_ext();
        t_led();
        t_susp();
        t_wake();
        t_de();
        conclude();
    end
endmodule // tb_top
